// *** swl_bus_if.sv ***
// Single-wire bus: both open-drain drivers, strong pullup, wired level
`timescale 1ns/1ps
interface swl_bus_if;
    logic m_out;
    logic m_oe_n;
    logic m_spu;
    logic d_out;
    logic d_oe_n;
    logic dq;
    // Wired-AND with pullup: any enabled low driver wins
    assign dq = !((!m_oe_n && !m_out) || (!d_oe_n && !d_out));
    modport master (output m_out, output m_oe_n, output m_spu, input dq);
    modport dev (output d_out, output d_oe_n, input dq, input m_spu);
endinterface : swl_bus_if

// *** swl_defines.svh ***
// Timing counts, command codes and reset values of the single-wire link
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH
`define SWL_CLK_MHZ 50
// Master timing, microseconds or milliseconds then cycles
`define SWL_T_INIT_US 2
`define SWL_INIT_CYC (`SWL_T_INIT_US * `SWL_CLK_MHZ)
`define SWL_T_LOW0_US 65
`define SWL_LOW0_CYC (`SWL_T_LOW0_US * `SWL_CLK_MHZ)
`define SWL_T_SLOT_US 70
`define SWL_SLOT_CYC (`SWL_T_SLOT_US * `SWL_CLK_MHZ)
`define SWL_T_REC_US 5
`define SWL_REC_CYC (`SWL_T_REC_US * `SWL_CLK_MHZ)
`define SWL_T_MSAMP_US 12
`define SWL_MSAMP_CYC (`SWL_T_MSAMP_US * `SWL_CLK_MHZ)
`define SWL_T_RSTL_US 1000
`define SWL_RSTL_CYC (`SWL_T_RSTL_US * `SWL_CLK_MHZ)
`define SWL_T_RSTH_US 480
`define SWL_RSTH_CYC (`SWL_T_RSTH_US * `SWL_CLK_MHZ)
`define SWL_T_PSAMP_US 70
`define SWL_PSAMP_CYC (`SWL_T_PSAMP_US * `SWL_CLK_MHZ)
`define SWL_CONVERSION_TIME_MS 400
`define SWL_CONV_CYC (`SWL_CONVERSION_TIME_MS * 1000 * `SWL_CLK_MHZ)
`define SWL_T_COPY_MS 10
`define SWL_COPY_CYC (`SWL_T_COPY_MS * 1000 * `SWL_CLK_MHZ)
// Device timing
`define SWL_T_DHOLD_US 30
`define SWL_DHOLD_CYC (`SWL_T_DHOLD_US * `SWL_CLK_MHZ)
`define SWL_T_RSTDET_US 480
`define SWL_RSTDET_CYC (`SWL_T_RSTDET_US * `SWL_CLK_MHZ)
`define SWL_T_PDH_US 30
`define SWL_PDH_CYC (`SWL_T_PDH_US * `SWL_CLK_MHZ)
`define SWL_T_PDL_US 120
`define SWL_PDL_CYC (`SWL_T_PDL_US * `SWL_CLK_MHZ)
// Command bytes
`define SWL_CMD_MATCH 8'h55
`define SWL_CMD_SKIP 8'hCC
`define SWL_CMD_CONV 8'h44
`define SWL_CMD_WRSP 8'h4E
`define SWL_CMD_RDSP 8'hBE
`define SWL_CMD_COPY 8'h48
`define SWL_CMD_RECALL 8'hB8
`define SWL_CMD_SUPPLY 8'hB4
// CRC polynomial (reflected), reset values of stored bytes
`define SWL_CRC_POLY 8'h8C
`define SWL_CFG_RST 24'h7F0000
`define SWL_SP_RSV 24'h000000
`endif

// *** swl_device.sv ***
// Thermometer end of the single-wire link: slots, presence, commands
`timescale 1ns/1ps
`include "swl_defines.svh"
module swl_device #(
    parameter logic [63:0] ROM_ID = 64'h0123456789ABCDEF, // Arbitrary
    parameter logic [15:0] RSTDET_CYC = 16'(`SWL_RSTDET_CYC),
    parameter logic [15:0] PDL_CYC = 16'(`SWL_PDL_CYC)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    swl_bus_if.dev bus,
    input wire logic [15:0] temp_in,
    input wire logic busy_in,
    input wire logic parasite_in,
    input wire logic [23:0] nv_in,
    output logic [23:0] alarm_cfg,
    output logic conv_req,
    output logic copy_req,
    output logic recall_req
);
    import swl_pkg::*;
    typedef struct packed {
        swl_dst_type st;
        logic s1, s2, prev;
        logic [15:0] lowcnt;
        logic [15:0] scnt;
        logic sact, txb, ok;
        logic [6:0] bitn;
        logic [7:0] sh;
        logic [23:0] w;
        logic [23:0] cfg;
        logic [15:0] tmp;
        logic [7:0] crc;
        logic oe_n, conv, copy, recall;
    } swl_dev_state_type;

    swl_dev_state_type r_reg, r_next;
    logic fall, rise, b, tx;
    logic [7:0] nb;
    logic [63:0] pad;

    // Scratchpad bytes 0..7 as sent, byte 0 in the low bits
    assign pad = {`SWL_SP_RSV, r_reg.cfg, r_reg.tmp};
    assign fall = r_reg.prev && !r_reg.s2;
    assign rise = !r_reg.prev && r_reg.s2;
    assign b = r_reg.s2;
    assign nb = {b, r_reg.sh[7:1]};
    assign tx = (r_reg.st == SWL_D_READ) || (r_reg.st == SWL_D_STATUS) ||
                (r_reg.st == SWL_D_SUPPLY);

    always_comb begin
        r_next = r_reg;
        r_next.conv = 1'b0;
        r_next.copy = 1'b0;
        r_next.recall = 1'b0;
        // Only the second stage is read by logic
        r_next.s1 = bus.dq;
        r_next.s2 = r_reg.s1;
        r_next.prev = r_reg.s2;
        // Own presence or zero is no reset: count foreign lows
        if (r_reg.s2 || !r_reg.oe_n) begin
            r_next.lowcnt = 16'h0000;
        end else if (r_reg.lowcnt != 16'hFFFF) begin
            r_next.lowcnt = r_reg.lowcnt + 16'h0001;
        end
        if (rise && r_reg.lowcnt >= RSTDET_CYC) begin
            // Long low ended: any transaction restarts
            r_next.st = SWL_D_PDW;
            r_next.scnt = 16'h0000;
            r_next.sact = 1'b0;
            r_next.oe_n = 1'b1;
        end else if (r_reg.st == SWL_D_PDW) begin
            r_next.scnt = r_reg.scnt + 16'h0001;
            if (r_reg.scnt == 16'(`SWL_PDH_CYC - 1)) begin
                r_next.oe_n = 1'b0;
                r_next.st = SWL_D_PDL;
                r_next.scnt = 16'h0000;
            end
        end else if (r_reg.st == SWL_D_PDL) begin
            r_next.scnt = r_reg.scnt + 16'h0001;
            if (r_reg.scnt == PDL_CYC - 16'h0001) begin
                r_next.oe_n = 1'b1;
                r_next.st = SWL_D_ROM;
                r_next.bitn = 7'h00;
            end
        end else if (fall && !r_reg.sact) begin
            r_next.sact = 1'b1;
            r_next.scnt = 16'h0000;
            unique case (r_reg.st)
                // Data LSB first from byte 0, then CRC
                SWL_D_READ: r_next.txb = r_reg.bitn[6] ?
                    r_reg.crc[r_reg.bitn[2:0]] : pad[r_reg.bitn[5:0]];
                SWL_D_STATUS: r_next.txb = !busy_in;
                SWL_D_SUPPLY: r_next.txb = !parasite_in;
                default: r_next.txb = 1'b1;
            endcase
            // Zero pulls low at once, one leaves bus released
            r_next.oe_n = !(tx && r_next.txb == 1'b0);
        end else if (r_reg.sact) begin
            r_next.scnt = r_reg.scnt + 16'h0001;
            // Hold 30 us, past data-valid, well inside the slot
            if (r_reg.scnt == 16'(`SWL_DHOLD_CYC - 1)) begin
                r_next.oe_n = 1'b1;
                r_next.sact = 1'b0;
                r_next.bitn = r_reg.bitn + 7'h01;
                // Write-slot sample point, 30 us after the fall
                unique case (r_reg.st)
                    SWL_D_ROM: begin
                        r_next.sh = nb;
                        r_next.ok = 1'b1;
                        if (r_reg.bitn == 7'h07) begin
                            r_next.bitn = 7'h00;
                            r_next.st = (nb == `SWL_CMD_MATCH) ?
                                SWL_D_MATCH : (nb == `SWL_CMD_SKIP) ?
                                SWL_D_FUNC : SWL_D_IDLE;
                        end
                    end
                    SWL_D_MATCH: begin
                        if (b != ROM_ID[r_reg.bitn[5:0]]) begin
                            r_next.ok = 1'b0;
                        end
                        if (r_reg.bitn == 7'h3F) begin
                            r_next.bitn = 7'h00;
                            r_next.st = (r_next.ok) ? SWL_D_FUNC :
                                                      SWL_D_IDLE;
                        end
                    end
                    SWL_D_FUNC: begin
                        r_next.sh = nb;
                        if (r_reg.bitn == 7'h07) begin
                            r_next.bitn = 7'h00;
                            r_next.crc = 8'h00;
                            r_next.st = SWL_D_IDLE;
                            unique case (nb)
                                `SWL_CMD_CONV: begin
                                    r_next.conv = 1'b1;
                                    r_next.st = SWL_D_STATUS;
                                end
                                `SWL_CMD_RECALL: begin
                                    r_next.recall = 1'b1;
                                    r_next.cfg = nv_in;
                                    r_next.st = SWL_D_STATUS;
                                end
                                `SWL_CMD_RDSP: begin
                                    r_next.tmp = temp_in;
                                    r_next.st = SWL_D_READ;
                                end
                                `SWL_CMD_WRSP: r_next.st = SWL_D_WRITE;
                                `SWL_CMD_COPY: r_next.copy = 1'b1;
                                `SWL_CMD_SUPPLY: r_next.st = SWL_D_SUPPLY;
                                default: r_next.st = SWL_D_IDLE;
                            endcase
                        end
                    end
                    SWL_D_WRITE: begin
                        // High, low alarm, then configuration
                        r_next.w = {b, r_reg.w[23:1]};
                        if (r_reg.bitn == 7'h17) begin
                            r_next.cfg = r_next.w;
                            r_next.st = SWL_D_IDLE;
                        end
                    end
                    SWL_D_READ: begin
                        if (!r_reg.bitn[6]) begin
                            r_next.crc = swl_crc8(r_reg.crc, r_reg.txb);
                        end
                        if (r_reg.bitn == 7'h47) begin
                            r_next.st = SWL_D_IDLE;
                        end
                    end
                    default: r_next.bitn = r_reg.bitn;
                endcase
            end
        end
    end

    // Whole state in one register; clock enable freezes it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.s1 <= 1'b1;
            r_reg.s2 <= 1'b1;
            r_reg.prev <= 1'b1;
            r_reg.oe_n <= 1'b1;
            r_reg.cfg <= `SWL_CFG_RST;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign bus.d_out = 1'b0;
    assign bus.d_oe_n = r_reg.oe_n;
    assign alarm_cfg = r_reg.cfg;
    assign conv_req = r_reg.conv;
    assign copy_req = r_reg.copy;
    assign recall_req = r_reg.recall;
endmodule : swl_device

// *** swl_master.sv ***
// Bus master end of the single-wire link with its command FIFO
`timescale 1ns/1ps
`include "swl_defines.svh"
module swl_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp, rp;
        logic [AW:0] cnt;
        logic full, empty;
    } swl_fifo_state_type;

    swl_fifo_state_type r_reg, r_next;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;

    assign push = in_valid && !r_reg.full;
    assign pop = out_valid && out_ready;

    // Pointers wrap; flags are registered so ready is glitch-free
    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 :
                        r_reg.wp + AW'(1);
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(DEPTH - 1)) ? '0 :
                        r_reg.rp + AW'(1);
        end
        r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        r_next.full = (r_next.cnt == (AW+1)'(DEPTH));
        r_next.empty = (r_next.cnt == '0);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.empty <= 1'b1;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // Storage has no reset; contents only matter once pushed
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[r_reg.wp] <= in_data;
        end
    end

    assign in_ready = !r_reg.full;
    assign out_valid = !r_reg.empty;
    assign out_data = mem[r_reg.rp];
endmodule : swl_fifo

module swl_master #(
    parameter logic [24:0] RSTL_CYC = 25'(`SWL_RSTL_CYC),
    parameter logic [24:0] RSTH_CYC = 25'(`SWL_RSTH_CYC),
    parameter logic [24:0] CONV_CYC = 25'(`SWL_CONV_CYC),
    parameter logic [24:0] COPY_CYC = 25'(`SWL_COPY_CYC),
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    swl_bus_if.master bus,
    input wire logic cmd_valid,
    input wire swl_pkg::swl_op_type cmd_op,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_crc_ok,
    output logic presence,
    output logic busy
);
    import swl_pkg::*;
    typedef struct packed {
        swl_mst_type st;
        logic [24:0] cnt;
        logic [2:0] bitn;
        logic [7:0] sh;
        swl_op_type op;
        logic arg;
        logic [7:0] crc;
        logic oe_n, spu, rv, pres, busy, crok;
        logic s1, s2;
    } swl_mst_state_type;

    swl_mst_state_type r_reg, r_next;
    swl_cmd_type fin, fout;
    logic f_valid, f_ready, wr0;

    assign fin = '{op: cmd_op, data: cmd_data};
    // Engine pulls a command only when idle, so the FIFO fills
    assign f_ready = (r_reg.st == SWL_M_IDLE);
    assign wr0 = (r_reg.op == SWL_OP_WRITE) && !r_reg.sh[0];

    swl_fifo #(.W($bits(swl_cmd_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(cmd_valid),
        .in_data(fin),
        .in_ready(cmd_ready),
        .out_valid(f_valid),
        .out_data(fout),
        .out_ready(f_ready)
    );

    always_comb begin
        r_next = r_reg;
        r_next.rv = 1'b0;
        // Line passes two flops before use
        r_next.s1 = bus.dq;
        r_next.s2 = r_reg.s1;
        r_next.cnt = r_reg.cnt + 25'h0000001;
        unique case (r_reg.st)
            SWL_M_IDLE: begin
                r_next.busy = f_valid;
                r_next.cnt = 25'h0000000;
                r_next.bitn = 3'h0;
                if (f_valid) begin
                    r_next.op = fout.op;
                    r_next.sh = fout.data;
                    r_next.arg = fout.data[0];
                    // Select and address-all bytes go as plain writes
                    unique case (fout.op)
                        SWL_OP_RESET: begin
                            r_next.st = SWL_M_RLOW;
                            r_next.oe_n = 1'b0;
                        end
                        SWL_OP_PULLUP: begin
                            r_next.st = SWL_M_SPU;
                            r_next.spu = 1'b1;
                        end
                        default: begin
                            // Reads queued after a read command start after
                            // its last write slot's recovery and one idle cycle
                            r_next.st = SWL_M_SLOT;
                            r_next.oe_n = 1'b0;
                            if (fout.op == SWL_OP_READ && fout.data[0]) begin
                                r_next.crc = 8'h00;
                            end
                        end
                    endcase
                end
            end
            SWL_M_RLOW: begin
                if (r_reg.cnt == RSTL_CYC - 25'h0000001) begin
                    r_next.oe_n = 1'b1;
                    r_next.st = SWL_M_RHIGH;
                    r_next.cnt = 25'h0000000;
                end
            end
            SWL_M_RHIGH: begin
                if (r_reg.cnt == 25'(`SWL_PSAMP_CYC)) begin
                    r_next.pres = !r_reg.s2;
                end
                if (r_reg.cnt == RSTH_CYC - 25'h0000001) begin
                    r_next.st = SWL_M_IDLE;
                    r_next.rv = 1'b1;
                end
            end
            SWL_M_SLOT: begin
                // Short opening low, zero keeps it low
                if (r_reg.cnt == 25'(`SWL_INIT_CYC - 1) && !wr0) begin
                    r_next.oe_n = 1'b1;
                end
                if (r_reg.cnt == 25'(`SWL_LOW0_CYC - 1)) begin
                    r_next.oe_n = 1'b1;
                end
                // Late sample, still inside data-valid
                if (r_reg.op == SWL_OP_READ &&
                    r_reg.cnt == 25'(`SWL_MSAMP_CYC)) begin
                    r_next.sh = {r_reg.s2, r_reg.sh[7:1]};
                    r_next.crc = swl_crc8(r_reg.crc, r_reg.s2);
                end
                if (r_reg.cnt == 25'(`SWL_SLOT_CYC - 1)) begin
                    r_next.st = SWL_M_REC;
                    r_next.cnt = 25'h0000000;
                    if (r_reg.op == SWL_OP_WRITE) begin
                        r_next.sh = {1'b0, r_reg.sh[7:1]};
                    end
                end
            end
            SWL_M_REC: begin
                if (r_reg.cnt == 25'(`SWL_REC_CYC - 1)) begin
                    r_next.cnt = 25'h0000000;
                    if (r_reg.bitn == 3'h7) begin
                        r_next.st = SWL_M_IDLE;
                        r_next.rv = 1'b1;
                    end else begin
                        r_next.bitn = r_reg.bitn + 3'h1;
                        r_next.st = SWL_M_SLOT;
                        r_next.oe_n = 1'b0;
                    end
                end
            end
            SWL_M_SPU: begin
                // Bus held high, no other activity
                if (r_reg.cnt == (r_reg.arg ? COPY_CYC : CONV_CYC) -
                                 25'h0000001) begin
                    r_next.spu = 1'b0;
                    r_next.st = SWL_M_IDLE;
                    r_next.rv = 1'b1;
                end
            end
            default: r_next.st = SWL_M_IDLE;
        endcase
        // Intact data plus CRC byte leaves zero behind
        r_next.crok = (r_next.crc == 8'h00);
    end

    // Whole engine state in one register; clock enable freezes it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.oe_n <= 1'b1;
            r_reg.s1 <= 1'b1;
            r_reg.s2 <= 1'b1;
            r_reg.crok <= 1'b1;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign bus.m_out = 1'b0;
    assign bus.m_oe_n = r_reg.oe_n;
    assign bus.m_spu = r_reg.spu;
    assign rsp_valid = r_reg.rv;
    assign rsp_data = r_reg.sh;
    // Flag kept in a flop so the output is glitch-free
    assign rsp_crc_ok = r_reg.crok;
    assign presence = r_reg.pres;
    assign busy = r_reg.busy;
endmodule : swl_master

// *** swl_monitor.sv ***
// Concurrent checks on the single-wire bus between both link ends
`timescale 1ns/1ps
module swl_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic m_out,
    input wire logic m_oe_n,
    input wire logic m_spu,
    input wire logic d_out,
    input wire logic d_oe_n,
    input wire logic dq
);
    logic [15:0] m_lo;
    logic [15:0] m_hi;
    logic [15:0] d_lo;
    logic [15:0] l_last;
    // Run lengths of each driver; high count saturates on long idles
    always_ff @(posedge clk) begin
        if (!nrst) begin
            m_lo <= 16'h0000;
            m_hi <= 16'hFFFF;
            d_lo <= 16'h0000;
            l_last <= 16'h0000;
        end else begin
            m_lo <= m_oe_n ? 16'h0000 : m_lo + 16'h0001;
            m_hi <= !m_oe_n ? 16'h0000 : (&m_hi ? m_hi : m_hi + 16'h0001);
            d_lo <= d_oe_n ? 16'h0000 : d_lo + 16'h0001;
            if ($rose(m_oe_n)) l_last <= m_lo;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    AST_OPEN_DRAIN: assert property (!m_out && !d_out)
        else $error("driver data not held low");
    AST_INIT_LOW: assert property (
        $rose(m_oe_n) |-> m_lo >= 16'h0032)
        else $error("master low pulse too short");
    AST_SLOT_REC: assert property (
        $fell(m_oe_n) |-> m_hi >= 16'h0032 &&
        17'(m_hi) + 17'(l_last) >= 17'h00BEA)
        else $error("slot or recovery too short");
    AST_PRES_DELAY: assert property ($fell(d_oe_n) && m_oe_n |->
        m_hi >= 16'h02EE && m_hi <= 16'h0BB8)
        else $error("presence start out of window");
    AST_ZERO_EARLY: assert property ($fell(d_oe_n) && !m_oe_n |->
        m_lo <= 16'h00FA)
        else $error("returned zero starts late");
    AST_ZERO_HOLD: assert property (
        $rose(d_oe_n) |-> d_lo >= 16'h02EE)
        else $error("device low released too early");
    AST_DEV_MAX: assert property (d_lo <= 16'h2EE0)
        else $error("device holds line too long");
    AST_SPU_HIGH: assert property (
        m_spu |-> m_oe_n && d_oe_n && dq)
        else $error("line pulled low under strong pullup");
endmodule : swl_monitor

// *** swl_pkg.sv ***
// Types and CRC helper shared by both link ends
package swl_pkg;
`include "swl_defines.svh"
    typedef enum logic [1:0] {
        SWL_OP_RESET = 2'h0,
        SWL_OP_WRITE = 2'h1,
        SWL_OP_READ = 2'h2,
        SWL_OP_PULLUP = 2'h3
    } swl_op_type;
    typedef enum logic [2:0] {
        SWL_M_IDLE = 3'h0, SWL_M_RLOW = 3'h1, SWL_M_RHIGH = 3'h2,
        SWL_M_SLOT = 3'h3, SWL_M_REC = 3'h4, SWL_M_SPU = 3'h5
    } swl_mst_type;
    typedef enum logic [3:0] {
        SWL_D_IDLE = 4'h0, SWL_D_PDW = 4'h1, SWL_D_PDL = 4'h2,
        SWL_D_ROM = 4'h3, SWL_D_MATCH = 4'h4, SWL_D_FUNC = 4'h5,
        SWL_D_WRITE = 4'h6, SWL_D_READ = 4'h7, SWL_D_STATUS = 4'h8,
        SWL_D_SUPPLY = 4'h9
    } swl_dst_type;
    typedef struct packed {
        swl_op_type op;
        logic [7:0] data;
    } swl_cmd_type;
    // One step of the bus CRC, data taken LSB first
    function automatic logic [7:0] swl_crc8(input logic [7:0] c,
                                            input logic b);
        logic fb;
        fb = c[0] ^ b;
        swl_crc8 = {1'b0, c[7:1]} ^ (fb ? `SWL_CRC_POLY : 8'h00);
    endfunction : swl_crc8
endpackage : swl_pkg

// *** tb_top.sv ***
// Testbench joining the master and device ends over one bus
`timescale 1ns/1ps
`include "swl_defines.svh"
module tb_top;
    import swl_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    logic parasite_in = 1'b1;
    logic ce = 1'b1;
    logic busy_in = 1'b0;
    logic [15:0] temp_in = 16'h0000;
    logic [23:0] nv_in = 24'h000000;
    logic [23:0] alarm_cfg;
    logic [2:0] req_seen;
    logic conv_req, copy_req, recall_req;
    swl_op_type cmd_op = SWL_OP_RESET;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] rsp_data;
    logic cmd_ready, rsp_valid, rsp_crc_ok, presence, busy;
    int err_total = 0;
    int check_count = 0;
    swl_bus_if swl_bus_if_i ();
    // Reset detect stays above the write-zero low time
    swl_master #(.RSTL_CYC(25'h1388), .RSTH_CYC(25'h1DB0),
        .CONV_CYC(25'h64), .COPY_CYC(25'h64), .FIFO_DEPTH(8)) swl_master_i (
        .clk(clk), .nrst(nrst), .ce(ce), .bus(swl_bus_if_i.master),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_crc_ok(rsp_crc_ok), .presence(presence), .busy(busy));
    swl_device #(.RSTDET_CYC(16'h0FA0)) swl_device_i (
        .clk(clk), .nrst(nrst), .ce(ce), .bus(swl_bus_if_i.dev),
        .temp_in(temp_in), .busy_in(busy_in), .parasite_in(parasite_in),
        .nv_in(nv_in), .alarm_cfg(alarm_cfg), .conv_req(conv_req),
        .copy_req(copy_req), .recall_req(recall_req));
    swl_monitor swl_monitor_i (.clk(clk), .nrst(nrst),
        .m_out(swl_bus_if_i.m_out), .m_oe_n(swl_bus_if_i.m_oe_n),
        .m_spu(swl_bus_if_i.m_spu), .d_out(swl_bus_if_i.d_out),
        .d_oe_n(swl_bus_if_i.d_oe_n), .dq(swl_bus_if_i.dq));
    // Sticky record of device request pulses, too short to poll
    always @(posedge clk) begin
        if (!nrst) begin
            req_seen <= 3'h0;
        end else begin
            req_seen <= req_seen | {conv_req, copy_req, recall_req};
        end
    end
    // Free-running 50 MHz clock
    initial forever #10 clk = !clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One command, then a bounded wait for its response pulse
    task automatic send(input swl_op_type op, input logic [7:0] d);
        int n;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        // Hold the request until an edge that sees ready high
        while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #2;
        end
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
        for (n = 0; n < 40000 && rsp_valid !== 1'b1; n++) begin
            @(posedge clk);
            #2;
        end
        check({15'h0000, rsp_valid}, 16'h0001);
    endtask : send
    // Queue timed pullups until the FIFO refuses, then drain it
    task automatic test_fill();
        int n;
        int got;
        check(alarm_cfg[23:8], 16'(`SWL_CFG_RST >> 8));
        check({8'h00, alarm_cfg[7:0]}, {8'h00, 8'(`SWL_CFG_RST)});
        cmd_valid = 1'b1;
        cmd_op = SWL_OP_PULLUP;
        cmd_data = 8'h01;
        n = 0;
        while (cmd_ready === 1'b1 && n < 20) begin
            @(posedge clk);
            #2;
            n++;
        end
        cmd_valid = 1'b0;
        check({15'h0000, cmd_ready}, 16'h0000);
        // Eight queued plus the one the engine holds
        check(16'(n), 16'h0009);
        check({15'h0000, swl_bus_if_i.m_spu}, 16'h0001);
        // Clock enable low: engine frozen, no response may appear
        got = 0;
        ce = 1'b0;
        repeat (200) begin
            @(posedge clk);
            #2;
            if (rsp_valid === 1'b1) got++;
        end
        ce = 1'b1;
        check(16'(got), 16'h0000);
        check({15'h0000, swl_bus_if_i.m_spu}, 16'h0001);
        got = 0;
        repeat (3000) begin
            @(posedge clk);
            #2;
            if (rsp_valid === 1'b1) got++;
        end
        check(16'(got), 16'(n));
        check({15'h0000, busy}, 16'h0000);
        $display("test_fill done");
    endtask : test_fill
    // Reset, address-all, supply query, one byte of returned zeros
    task automatic test_supply();
        send(SWL_OP_RESET, 8'h00);
        check({15'h0000, presence}, 16'h0001);
        send(SWL_OP_WRITE, 8'hCC);
        send(SWL_OP_WRITE, 8'hB4);
        send(SWL_OP_READ, 8'h01);
        check({8'h00, rsp_data}, 16'h0000);
        check({15'h0000, rsp_crc_ok}, 16'h0001);
        check({15'h0000, swl_bus_if_i.dq}, 16'h0001);
        check({13'h0000, req_seen}, 16'h0000);
        $display("test_supply done");
    endtask : test_supply
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge clk);
        #2;
        nrst = 1'b1;
        test_fill();
        test_supply();
        end_of_test();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (130000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule : tb_top
